// ### logic/diag_flags_pkg.sv
// constants for the diagnostic status and flag register bank
package diag_flags_pkg;
  // register offsets (byte addresses in the diagnostic page)
  localparam logic [7:0] OFF_SOFT_COMMAND_STATUS = 8'h6e;
  localparam logic [7:0] OFF_ALARM_FLAGS_ONE = 8'h70;
  localparam logic [7:0] OFF_ALARM_FLAGS_TWO = 8'h71;
  localparam logic [7:0] OFF_WARNING_FLAGS_ONE = 8'h74;
  localparam logic [7:0] OFF_MONITOR_VALID = 8'h7f;
  // status/control bit positions
  localparam int POS_TXDIS_MIRROR = 7;
  localparam int POS_SOFT_TXDIS = 6;
  localparam int POS_FAULT_MIRROR = 2;
  localparam int POS_LOS_MIRROR = 1;
  localparam int POS_NOT_READY = 0;
  // reset values
  localparam logic SOFT_TXDIS_RESET = 1'b0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  // response time budget
  localparam int RESPONSE_MS = 100;
  localparam int CLK_HZ = 50000000;
  localparam int RESPONSE_CYCLES = RESPONSE_MS * (CLK_HZ / 1000);
  // latency from a pin change to the register copy
  localparam int MIRROR_LATENCY = 4;
endpackage : diag_flags_pkg

// ### logic/optical_module_diag_status_flags.sv
// diagnostic status/control byte and alarm/warning flag bytes
// Notes on behaviour
// - bit 7 of status byte follows the transmit-disable pin level.
// - bit 6 is a software transmit-disable, host readable and writable.
// - transmitter is off when bit 6 or the disable pin is high.
// - bit 2 follows the transmit-fault output.
// - bit 1 follows the receive loss-of-signal output.
// - bit 0 reads 0 once monitor values are valid, else 1.
// - commands and mirrors take effect well inside 100 ms.
// - alarm one bit 7 set when temperature above high alarm.
// - alarm one bit 6 set when temperature below low alarm.
// - alarm one bit 5 set when supply above high alarm.
// - alarm one bit 4 set when supply below low alarm.
// - alarm one bit 3 set when bias above high alarm.
// - alarm one bit 2 set when bias below low alarm.
// - alarm one bit 1 set when transmit power above high alarm.
// - alarm one bit 0 set when transmit power below low alarm.
// - alarm two bit 7 set when receive power above high alarm.
// - alarm two bit 6 set when receive power below low alarm; rest zero.
// - warning one bit 7 set when temperature above high warning.
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module optical_module_diag_status_flags
  import diag_flags_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tx_disable_pin,
  input wire logic tx_fault_state,
  input wire logic receive_signal_lost_mirror,
  input wire logic monitor_valid,
  input wire logic [15:0] temp_value,
  input wire logic [15:0] temp_high_alarm,
  input wire logic [15:0] temp_low_alarm,
  input wire logic [15:0] temp_high_warning,
  input wire logic [15:0] vcc_value,
  input wire logic [15:0] vcc_high_alarm,
  input wire logic [15:0] vcc_low_alarm,
  input wire logic [15:0] bias_value,
  input wire logic [15:0] bias_high_alarm,
  input wire logic [15:0] bias_low_alarm,
  input wire logic [15:0] txpwr_value,
  input wire logic [15:0] txpwr_high_alarm,
  input wire logic [15:0] txpwr_low_alarm,
  input wire logic [15:0] rxpwr_value,
  input wire logic [15:0] rxpwr_high_alarm,
  input wire logic [15:0] rxpwr_low_alarm,
  output logic tx_off
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change accepted when stages two and three agree

  logic [2:0] txdis_sync_q;
  logic [2:0] fault_sync_q;
  logic [2:0] los_sync_q;
  logic txdis_q;
  logic fault_q;
  logic los_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txdis_sync_q <= SYNC_RESET;
      fault_sync_q <= SYNC_RESET;
      los_sync_q <= SYNC_RESET;
    end else begin
      txdis_sync_q <= {txdis_sync_q[1:0], tx_disable_pin};
      fault_sync_q <= {fault_sync_q[1:0], tx_fault_state};
      los_sync_q <= {los_sync_q[1:0], receive_signal_lost_mirror};
    end
  end

  // a lone glitch that only reaches one stage never shows up in the register
  wire txdis_agree = txdis_sync_q[1] == txdis_sync_q[2];
  wire fault_agree = fault_sync_q[1] == fault_sync_q[2];
  wire los_agree = los_sync_q[1] == los_sync_q[2];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txdis_q <= 1'b0;
      fault_q <= 1'b0;
      los_q <= 1'b0;
    end else begin
      if (txdis_agree) txdis_q <= txdis_sync_q[2];
      if (fault_agree) fault_q <= fault_sync_q[2];
      if (los_agree) los_q <= los_sync_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  wire sel_status = reg_addr == OFF_SOFT_COMMAND_STATUS;
  wire sel_alarm1 = reg_addr == OFF_ALARM_FLAGS_ONE;
  wire sel_alarm2 = reg_addr == OFF_ALARM_FLAGS_TWO;
  wire sel_warn1 = reg_addr == OFF_WARNING_FLAGS_ONE;
  wire sel_valid = reg_addr == OFF_MONITOR_VALID;

  logic soft_txdis_q;
  logic soft_txdis_d;

  // only bit 6 is writable; the rest of the byte drops writes
  assign soft_txdis_d = (reg_wr && sel_status) ? reg_wdata[POS_SOFT_TXDIS] : soft_txdis_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) soft_txdis_q <= SOFT_TXDIS_RESET;
    else soft_txdis_q <= soft_txdis_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter disable

  logic tx_off_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) tx_off_q <= 1'b0;
    else tx_off_q <= soft_txdis_q | txdis_q;
  end
  assign tx_off = tx_off_q;

  // monitor valid is from on-chip logic on this clock; no synchroniser
  logic not_ready_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) not_ready_q <= 1'b1;
    else not_ready_q <= ~monitor_valid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold comparison

  function automatic logic above(input logic [15:0] v, input logic [15:0] t);
    above = v > t;
  endfunction

  function automatic logic below(input logic [15:0] v, input logic [15:0] t);
    below = v < t;
  endfunction

  // temperature is two's complement; flip the sign bit to compare unsigned
  wire [15:0] temp_u = temp_value ^ 16'h8000;
  wire [15:0] temp_ha_u = temp_high_alarm ^ 16'h8000;
  wire [15:0] temp_la_u = temp_low_alarm ^ 16'h8000;
  wire [15:0] temp_hw_u = temp_high_warning ^ 16'h8000;

  wire [7:0] alarm1_d = {
    above(temp_u, temp_ha_u),
    below(temp_u, temp_la_u),
    above(vcc_value, vcc_high_alarm),
    below(vcc_value, vcc_low_alarm),
    above(bias_value, bias_high_alarm),
    below(bias_value, bias_low_alarm),
    above(txpwr_value, txpwr_high_alarm),
    below(txpwr_value, txpwr_low_alarm)
  };
  wire [7:0] alarm2_d = {
    above(rxpwr_value, rxpwr_high_alarm),
    below(rxpwr_value, rxpwr_low_alarm),
    6'h00
  };
  // only the high temperature warning exists here; the rest read zero
  wire [7:0] warn1_d = {above(temp_u, temp_hw_u), 7'h00};

  logic [7:0] alarm1_q;
  logic [7:0] alarm2_q;
  logic [7:0] warn1_q;

  // flags follow the live condition, not sticky, cleared once it goes away
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm1_q <= REG_RESET;
      alarm2_q <= REG_RESET;
      warn1_q <= REG_RESET;
    end else begin
      alarm1_q <= alarm1_d & {8{monitor_valid}};
      alarm2_q <= alarm2_d & {8{monitor_valid}};
      warn1_q <= warn1_d & {8{monitor_valid}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  wire [7:0] status_byte = {txdis_q, soft_txdis_q, 3'h0, fault_q, los_q, not_ready_q};

  wire [7:0] rd_mux = sel_status ? status_byte :
                      sel_alarm1 ? alarm1_q :
                      sel_alarm2 ? alarm2_q :
                      sel_warn1 ? warn1_q :
                      sel_valid ? {7'h00, ~not_ready_q} :
                      8'h00;

  logic [7:0] rdata_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rdata_q <= REG_RESET;
    else if (reg_rd) rdata_q <= rd_mux;
    else rdata_q <= 8'h00;
  end
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_txdis_mirror_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (txdis_sync_q[2] == txdis_sync_q[1]) |=> txdis_q == $past(txdis_sync_q[2]))
    else $error("disable mirror did not follow pin");

  sequence s_status_write(bit v);
    reg_wr && sel_status && reg_wdata[POS_SOFT_TXDIS] == v;
  endsequence

  a_soft_txdis_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_status_write(1'b1) ##1 !reg_wr |-> soft_txdis_q)
    else $error("soft disable not stored");

  a_tx_off_or: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ##1 tx_off == ($past(soft_txdis_q) | $past(txdis_q)))
    else $error("transmit off not the or of both sources");

  a_soft_write_latency: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_status_write(1'b1) |-> ##[1:2] tx_off)
    else $error("soft disable too slow");

  a_fault_mirror: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(tx_fault_state) ##1 tx_fault_state [*4] |-> fault_q)
    else $error("fault mirror lags");

  a_los_mirror: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(receive_signal_lost_mirror) ##1 receive_signal_lost_mirror [*4] |-> los_q)
    else $error("loss mirror lags");

  a_ready_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    not_ready_q == ($past(reset_n) ? !$past(monitor_valid) : 1'b1))
    else $error("ready flag wrong");

  a_temp_high_alarm: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && $signed(temp_value) > $signed(temp_high_alarm) |=> alarm1_q[7])
    else $error("temperature high alarm missed");

  a_rx_low_alarm: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && rxpwr_value < rxpwr_low_alarm |=> alarm2_q[6] && alarm2_q[5:0] == 6'h00)
    else $error("receive low alarm wrong");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_rd && sel_status |=> reg_rdata[5:3] == 3'h0)
    else $error("reserved bits not zero");

  a_temp_high_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && $signed(temp_value) > $signed(temp_high_alarm)) |=> !alarm1_q[7])
    else $error("temperature high alarm stuck");

  a_temp_low_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && $signed(temp_value) < $signed(temp_low_alarm) |=> alarm1_q[6])
    else $error("temperature low alarm missed");

  a_temp_low_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && $signed(temp_value) < $signed(temp_low_alarm)) |=> !alarm1_q[6])
    else $error("temperature low alarm stuck");

  a_vcc_high_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && vcc_value > vcc_high_alarm |=> alarm1_q[5])
    else $error("supply high alarm missed");

  a_vcc_high_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && vcc_value > vcc_high_alarm) |=> !alarm1_q[5])
    else $error("supply high alarm stuck");

  a_vcc_low_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && vcc_value < vcc_low_alarm |=> alarm1_q[4])
    else $error("supply low alarm missed");

  a_vcc_low_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && vcc_value < vcc_low_alarm) |=> !alarm1_q[4])
    else $error("supply low alarm stuck");

  a_bias_high_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && bias_value > bias_high_alarm |=> alarm1_q[3])
    else $error("bias high alarm missed");

  a_bias_high_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && bias_value > bias_high_alarm) |=> !alarm1_q[3])
    else $error("bias high alarm stuck");

  a_bias_low_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && bias_value < bias_low_alarm |=> alarm1_q[2])
    else $error("bias low alarm missed");

  a_bias_low_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && bias_value < bias_low_alarm) |=> !alarm1_q[2])
    else $error("bias low alarm stuck");

  a_txpwr_high_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && txpwr_value > txpwr_high_alarm |=> alarm1_q[1])
    else $error("transmit power high alarm missed");

  a_txpwr_high_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && txpwr_value > txpwr_high_alarm) |=> !alarm1_q[1])
    else $error("transmit power high alarm stuck");

  a_txpwr_low_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && txpwr_value < txpwr_low_alarm |=> alarm1_q[0])
    else $error("transmit power low alarm missed");

  a_txpwr_low_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && txpwr_value < txpwr_low_alarm) |=> !alarm1_q[0])
    else $error("transmit power low alarm stuck");

  a_rxpwr_high_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && rxpwr_value > rxpwr_high_alarm |=> alarm2_q[7])
    else $error("receive power high alarm missed");

  a_rxpwr_high_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && rxpwr_value > rxpwr_high_alarm) |=> !alarm2_q[7])
    else $error("receive power high alarm stuck");

  a_rxpwr_low_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && rxpwr_value < rxpwr_low_alarm) |=> !alarm2_q[6])
    else $error("receive power low alarm stuck");

  a_temp_warn_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    monitor_valid && $signed(temp_value) > $signed(temp_high_warning) |=> warn1_q[7])
    else $error("temperature warning missed");

  a_temp_warn_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(monitor_valid && $signed(temp_value) > $signed(temp_high_warning)) |=> !warn1_q[7])
    else $error("temperature warning stuck");

  a_flags_masked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !monitor_valid |=> alarm1_q == 8'h00 && alarm2_q == 8'h00 && warn1_q == 8'h00)
    else $error("flags set before monitor valid");

  a_warn_reserved: assert property (@(posedge ref_clk) disable iff (!reset_n)
    warn1_q[6:0] == 7'h00 && alarm2_q[5:0] == 6'h00)
    else $error("reserved flag bits set");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");

  a_status_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_rd && sel_status |=> reg_rdata == $past(status_byte))
    else $error("status read wrong");

  a_valid_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reg_rd && sel_valid |=> reg_rdata == {7'h00, $past(~not_ready_q)})
    else $error("monitor valid read wrong");

  a_soft_txdis_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_status_write(1'b0) |=> !soft_txdis_q)
    else $error("soft disable not cleared");

  a_soft_txdis_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(reg_wr && sel_status) |=> $stable(soft_txdis_q))
    else $error("soft disable changed without write");

  a_pin_to_tx_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(tx_disable_pin) ##1 tx_disable_pin [*5] |-> tx_off)
    else $error("pin disable too slow");

  a_txdis_mirror_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(tx_disable_pin) ##1 !tx_disable_pin [*4] |-> !txdis_q)
    else $error("disable mirror stuck");

  a_fault_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(tx_fault_state) ##1 !tx_fault_state [*4] |-> !fault_q)
    else $error("fault mirror stuck");

  a_los_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(receive_signal_lost_mirror) ##1 !receive_signal_lost_mirror [*4] |-> !los_q)
    else $error("loss mirror stuck");

endmodule // optical_module_diag_status_flags

// ### testbench/diag_host_model.sv
// host controller model driving the register port
`timescale 1ns/10ps
module diag_host_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one-cycle strobes; the slave never stalls, so no wait loop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule // diag_host_model

// ### testbench/optical_module_diag_status_flags_tb.sv
// self-checking bench for the status and flag register bank
`timescale 1ns/10ps
module optical_module_diag_status_flags_tb;
  import diag_flags_pkg::*;
  typedef struct {logic [15:0] v; logic [7:0] a1; logic [7:0] a2; logic [7:0] w1;} row_t;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic tx_disable_pin = 1'b0;
  logic tx_fault_state = 1'b0;
  logic receive_signal_lost_mirror = 1'b0;
  logic monitor_valid = 1'b0;
  logic [15:0] val = 16'h0500;
  logic [15:0] hi_th = 16'h1000;
  logic [15:0] lo_th = 16'h0100;
  logic [15:0] warn_th = 16'h0800;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, tx_off;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // one value on every channel; temp is signed so 16'hff00 is low there only
  row_t rows [6] = '{'{16'h1001, 8'haa, 8'h80, 8'h80}, '{16'h00ff, 8'h55, 8'h40, 8'h00},
    '{16'hff00, 8'h6a, 8'h80, 8'h00}, '{16'h1000, 8'h00, 8'h00, 8'h80},
    '{16'h0100, 8'h00, 8'h00, 8'h00}, '{16'h0500, 8'h00, 8'h00, 8'h00}};
  always #10 ref_clk = ~ref_clk;
  diag_host_model u_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  optical_module_diag_status_flags u_optical_module_diag_status_flags (.ref_clk(ref_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_disable_pin(tx_disable_pin), .tx_fault_state(tx_fault_state),
    .receive_signal_lost_mirror(receive_signal_lost_mirror), .monitor_valid(monitor_valid),
    .temp_value(val), .temp_high_alarm(hi_th), .temp_low_alarm(lo_th), .temp_high_warning(warn_th),
    .vcc_value(val), .vcc_high_alarm(hi_th), .vcc_low_alarm(lo_th), .bias_value(val),
    .bias_high_alarm(hi_th), .bias_low_alarm(lo_th), .txpwr_value(val), .txpwr_high_alarm(hi_th),
    .txpwr_low_alarm(lo_th), .rxpwr_value(val), .rxpwr_high_alarm(hi_th), .rxpwr_low_alarm(lo_th),
    .tx_off(tx_off));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk($sformatf("byte %h", a), d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // generous ceiling; the sequence needs about 110 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    tick(5);
    reset_n <= 1'b1;
    val <= 16'h1001;
    rc(OFF_SOFT_COMMAND_STATUS, 8'h01);
    rc(OFF_ALARM_FLAGS_ONE, 8'h00);
    chk("tx_off", {7'h00, tx_off}, 8'h00);
    monitor_valid <= 1'b1;
    tick(2);
    rc(OFF_SOFT_COMMAND_STATUS, 8'h00);
    foreach (rows[i]) begin
      val <= rows[i].v;
      tick(2);
      rc(OFF_ALARM_FLAGS_ONE, rows[i].a1);
      rc(OFF_ALARM_FLAGS_TWO, rows[i].a2);
      rc(OFF_WARNING_FLAGS_ONE, rows[i].w1);
    end
    tx_disable_pin <= 1'b1;
    tick(6);
    rc(OFF_SOFT_COMMAND_STATUS, 8'h80);
    chk("tx_off", {7'h00, tx_off}, 8'h01);
    tx_disable_pin <= 1'b0;
    tx_fault_state <= 1'b1;
    receive_signal_lost_mirror <= 1'b1;
    tick(6);
    rc(OFF_SOFT_COMMAND_STATUS, 8'h06);
    chk("tx_off", {7'h00, tx_off}, 8'h00);
    tx_fault_state <= 1'b0;
    receive_signal_lost_mirror <= 1'b0;
    u_host.wr(OFF_SOFT_COMMAND_STATUS, 8'hff);
    tick(2);
    #1;
    chk("tx_off", {7'h00, tx_off}, 8'h01);
    rc(OFF_SOFT_COMMAND_STATUS, 8'h40);
    tick(1);
    #1;
    chk("idle rdata", reg_rdata, 8'h00);
    u_host.wr(OFF_ALARM_FLAGS_ONE, 8'hff);
    rc(OFF_ALARM_FLAGS_ONE, 8'h00);
    rc(8'h20, 8'h00);
    rc(OFF_MONITOR_VALID, 8'h01);
    u_host.wr(OFF_SOFT_COMMAND_STATUS, 8'h00);
    tick(2);
    #1;
    chk("tx_off", {7'h00, tx_off}, 8'h00);
    // reset in mid-run must drop the soft disable
    u_host.wr(OFF_SOFT_COMMAND_STATUS, 8'h40);
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    rc(OFF_SOFT_COMMAND_STATUS, 8'h00);
    // a one-cycle pin pulse must be filtered
    @(posedge ref_clk);
    tx_disable_pin <= 1'b1;
    tick(1);
    tx_disable_pin <= 1'b0;
    tick(6);
    rc(OFF_SOFT_COMMAND_STATUS, 8'h00);
    chk("tx_off", {7'h00, tx_off}, 8'h00);
    report_and_stop;
  end
endmodule // optical_module_diag_status_flags_tb
